/* logic/tdm_pkg.sv */
// Purpose: Constants shared by the transponder demodulator
// Assumes: 25 MHz system clock
// Notes:   Delays in microseconds, converted to cycles here
package tdm_pkg;
  localparam int unsigned CLK_MHZ        = 25;
  localparam logic [1:0]  RATE_2K        = 2'h0;
  localparam logic [1:0]  RATE_4K        = 2'h1;
  localparam logic [1:0]  RATE_8K        = 2'h2;
  localparam logic [1:0]  RATE_RSVD      = 2'h3;
  // Glitch filter delays at 2 kbit/s; halved per rate step
  localparam int unsigned GLITCH_US_1    = 48;
  localparam int unsigned GLITCH_US_2    = 80;
  localparam int unsigned GLITCH_US_3    = 144;
  // Phase filter typical delays
  localparam int unsigned PHASE_US_2K    = 1616;
  localparam int unsigned PHASE_US_4K    = 808;
  localparam int unsigned PHASE_US_8K    = 408;
  localparam int unsigned GLITCH_CYC_1   = GLITCH_US_1 * CLK_MHZ;
  localparam int unsigned GLITCH_CYC_2   = GLITCH_US_2 * CLK_MHZ;
  localparam int unsigned GLITCH_CYC_3   = GLITCH_US_3 * CLK_MHZ;
  localparam int unsigned PHASE_CYC_2K   = PHASE_US_2K * CLK_MHZ;
  localparam int unsigned PHASE_CYC_4K   = PHASE_US_4K * CLK_MHZ;
  localparam int unsigned PHASE_CYC_8K   = PHASE_US_8K * CLK_MHZ;
  localparam int unsigned US_CYC         = CLK_MHZ;
  // Start pattern: 8 short then 4 long periods
  localparam int unsigned START_SHORT    = 8;
  localparam int unsigned START_LONG     = 4;
  localparam logic [11:0] START_PATTERN  = 12'hFF0;
  localparam int unsigned FILT_LEN       = 3;
  localparam int unsigned CNT_W          = 18;
  localparam int unsigned PER_W          = 12;
  localparam int unsigned BYTE_W         = 8;
  localparam int unsigned BUF_DEPTH      = 4;
  typedef enum logic [1:0] {
    TDM_IDLE  = 2'b00,
    TDM_LEARN = 2'b01,
    TDM_HUNT  = 2'b11,
    TDM_DATA  = 2'b10
  } tdm_fsk_e;
endpackage

/* logic/tdm_demod.sv */
// Purpose: Digital side of the amplitude/frequency keyed transponder receiver
// Assumes: Analog front ends deliver sliced logic levels on the rx inputs
// Notes:   Timing parameters in microseconds; long counts are parameters
// What this block does
// [R1] Only one demodulator channel enabled at once
// [R2] Demodulated data drives the data output pin
// [R3] Amplitude inputs grounded while immobilizer disabled
// [R4] Rate code selects 2, 4, 8 kbit/s
// [R5] Programmable start delay and early start time
// [R6] Latency is start minus early plus filters
// [R7] Glitch filter adds rate scaled delay
// [R8] Phase filter adds 1616/808/408 us
// [R9] Frequency measured by counting clocks per period
// [R10] Resonance period learned, sets relative threshold
// [R11] Start bit: 8 short then 4 long
// [R12] Detected bit stream digitally filtered before use
// [R13] Received bits collected into byte buffer entries
// [R14] Bytes forwarded in arrival order; a byte completed while all 4 entries are full is dropped
module tdm_demod
  import tdm_pkg::*;
#(
  parameter int unsigned PHASE_2K = PHASE_CYC_2K,
  parameter int unsigned PHASE_4K = PHASE_CYC_4K,
  parameter int unsigned PHASE_8K = PHASE_CYC_8K
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // Configuration
  input  wire logic        immo_enable,
  input  wire logic        select_frequency,
  input  wire logic [1:0]  data_rate,
  input  wire logic [1:0]  glitch_setting,
  input  wire logic [7:0]  demod_start_delay,
  input  wire logic [7:0]  early_start_time,
  input  wire logic        dig_mod,
  input  wire logic [7:0]  bit_periods,
  // Receiver inputs from pins
  input  wire logic        amplitude_rx_input,
  input  wire logic        frequency_rx_input,
  // Outputs
  output logic             amplitude_ground,
  output logic             amplitude_active,
  output logic             frequency_active,
  output logic             start_found,
  output logic             demod_data_out
);
  typedef struct packed {
    logic [1:0]       ask_sync;
    logic [1:0]       fsk_sync;
    logic             fsk_prev;
    logic             ask_run;
    logic [CNT_W-1:0] lat_cnt;
    logic             ask_valid;
    logic [CNT_W-1:0] glitch_cnt;
    logic             ask_filt;
    tdm_fsk_e         fsk_state;
    logic [PER_W-1:0] per_cnt;
    logic [PER_W-1:0] threshold;
    logic [11:0]      shift;
    logic [FILT_LEN-1:0] filt;
    logic             fbit;
    logic [7:0]       bit_cnt;
    logic [2:0]       bit_idx;
    logic [BYTE_W-1:0] asm_byte;
    logic [BUF_DEPTH-1:0][BYTE_W-1:0] buf_mem;
    logic [1:0]       wr_ptr;
    logic [1:0]       rd_ptr;
    logic [2:0]       count;
    logic [BYTE_W-1:0] out_byte;
    logic [2:0]       out_idx;
    logic             out_busy;
    logic [7:0]       out_cnt;
    logic             start;
    logic             dout;
  } tdm_state_s;

  tdm_state_s st;
  tdm_state_s next_st;
  logic [CNT_W-1:0] glitch_cyc;
  logic [CNT_W-1:0] phase_cyc;
  logic [CNT_W-1:0] latency_cyc;
  logic             ask_en;
  logic             fsk_en;
  logic             fsk_edge;
  logic             short_per;
  logic             push;
  logic             pop;
  logic [CNT_W-1:0] start_cyc;
  logic [CNT_W-1:0] early_cyc;

  // One channel at most; frequency wins the select
  assign fsk_en = immo_enable & select_frequency;                         // [R1]
  assign ask_en = immo_enable & ~select_frequency;                        // [R1]

  always_comb begin
    case (data_rate)                                                     // [R4]
      RATE_2K: phase_cyc = CNT_W'(PHASE_2K);                              // [R8]
      RATE_4K: phase_cyc = CNT_W'(PHASE_4K);                              // [R8]
      RATE_8K: phase_cyc = CNT_W'(PHASE_8K);                              // [R8]
      default: phase_cyc = CNT_W'(PHASE_8K);
    endcase
    case (glitch_setting)                                                // [R7]
      2'h1:    glitch_cyc = CNT_W'(GLITCH_CYC_1);
      2'h2:    glitch_cyc = CNT_W'(GLITCH_CYC_2);
      2'h3:    glitch_cyc = CNT_W'(GLITCH_CYC_3);
      default: glitch_cyc = '0;
    endcase
    if (data_rate == RATE_4K) begin
      glitch_cyc = glitch_cyc >> 1;                                      // [R7]
    end else if (data_rate == RATE_8K || data_rate == RATE_RSVD) begin
      glitch_cyc = glitch_cyc >> 2;                                      // [R7]
    end
  end

  assign start_cyc   = CNT_W'(demod_start_delay * US_CYC);                // [R5]
  assign early_cyc   = CNT_W'(early_start_time * US_CYC);                 // [R5]
  // Glitch time is part of the gate, so the filtered level has settled when it opens
  assign latency_cyc = (start_cyc > early_cyc) ?
                       CNT_W'(start_cyc - early_cyc + phase_cyc + glitch_cyc) :
                       CNT_W'(phase_cyc + glitch_cyc);                   // [R6]
  assign fsk_edge    = st.fsk_sync[1] & ~st.fsk_prev;
  assign short_per   = st.per_cnt < st.threshold;
  assign pop         = ~st.out_busy && (st.count != 3'h0);

  always_comb begin
    next_st = st;
    push = 1'b0;
    next_st.ask_sync = {st.ask_sync[0], amplitude_rx_input};
    next_st.fsk_sync = {st.fsk_sync[0], frequency_rx_input};
    next_st.fsk_prev = st.fsk_sync[1];
    next_st.start = 1'b0;
    // Amplitude path: latency timer then glitch filter
    if (!ask_en || !dig_mod) begin
      next_st.ask_run = 1'b0;
      next_st.ask_valid = 1'b0;
      next_st.lat_cnt = '0;
    end else if (!st.ask_valid) begin
      next_st.ask_run = 1'b1;
      next_st.lat_cnt = st.lat_cnt + 1'b1;
      if (st.lat_cnt >= latency_cyc) begin
        next_st.ask_valid = 1'b1;                                        // [R6]
      end
    end
    if (st.ask_sync[1] == st.ask_filt) begin
      next_st.glitch_cnt = '0;
    end else if (st.glitch_cnt >= glitch_cyc) begin
      next_st.ask_filt = st.ask_sync[1];                                 // [R7]
      next_st.glitch_cnt = '0;
    end else begin
      next_st.glitch_cnt = st.glitch_cnt + 1'b1;
    end
    // Frequency path
    if (!fsk_en) begin
      next_st.fsk_state = TDM_IDLE;
      next_st.per_cnt = '0;
    end else begin
      if (fsk_edge) begin
        next_st.per_cnt = '0;
      end else if (st.per_cnt != '1) begin
        next_st.per_cnt = st.per_cnt + 1'b1;                             // [R9]
      end
      case (st.fsk_state)
        TDM_IDLE: begin
          // First edge only marks where a whole period begins
          if (fsk_edge) begin
            next_st.fsk_state = TDM_LEARN;
          end
        end
        TDM_LEARN: begin
          if (fsk_edge && st.per_cnt != '0) begin
            // Resonance period plus one sixteenth
            next_st.threshold = st.per_cnt + (st.per_cnt >> 4);          // [R10]
            next_st.fsk_state = TDM_HUNT;
          end
        end
        TDM_HUNT: begin
          if (fsk_edge) begin
            next_st.shift = {st.shift[10:0], ~short_per};
            if ({st.shift[10:0], ~short_per} == ~START_PATTERN) begin    // [R11]
              next_st.fsk_state = TDM_DATA;
              next_st.start = 1'b1;
              next_st.bit_cnt = '0;
              next_st.bit_idx = '0;
            end
          end
        end
        TDM_DATA: begin
          if (fsk_edge) begin
            next_st.filt = {st.filt[FILT_LEN-2:0], ~short_per};
            if (&next_st.filt) begin
              next_st.fbit = 1'b1;                                       // [R12]
            end else if (~|next_st.filt) begin
              next_st.fbit = 1'b0;                                       // [R12]
            end
            next_st.bit_cnt = st.bit_cnt + 1'b1;
            if (st.bit_cnt + 8'h01 >= bit_periods) begin
              next_st.bit_cnt = '0;
              next_st.asm_byte = {st.asm_byte[6:0], st.fbit};            // [R13]
              next_st.bit_idx = st.bit_idx + 1'b1;
              if (st.bit_idx == 3'h7 && st.count != 3'(BUF_DEPTH)) begin
                push = 1'b1;                                             // [R13]
              end
            end
          end
        end
        default: next_st.fsk_state = TDM_IDLE;
      endcase
    end
    // Byte buffer, drained MSB first in arrival order
    if (push) begin
      next_st.buf_mem[st.wr_ptr] = {st.asm_byte[6:0], st.fbit};          // [R14]
      next_st.wr_ptr = st.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_st.out_byte = st.buf_mem[st.rd_ptr];                          // [R14]
      next_st.rd_ptr = st.rd_ptr + 1'b1;
      next_st.out_busy = 1'b1;
      next_st.out_idx = '0;
      next_st.out_cnt = '0;
    end else if (st.out_busy) begin
      next_st.out_cnt = st.out_cnt + 1'b1;
      if (st.out_cnt + 8'h01 >= bit_periods) begin
        next_st.out_cnt = '0;
        next_st.out_idx = st.out_idx + 1'b1;
        if (st.out_idx == 3'h7) begin
          next_st.out_busy = 1'b0;
        end
      end
    end
    next_st.count = st.count + {2'h0, push} - {2'h0, pop};               // [R14]
    if (fsk_en) begin
      next_st.dout = st.out_busy ? st.out_byte[3'h7 - st.out_idx] : 1'b0;  // [R2]
    end else begin
      next_st.dout = ask_en & st.ask_valid & st.ask_filt;                // [R2]
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign amplitude_ground = ~immo_enable;                                 // [R3]
  assign amplitude_active = ask_en;
  assign frequency_active = fsk_en;
  assign start_found      = st.start;
  assign demod_data_out   = st.dout;
endmodule

/* test/tdm_demod_sva.sv */
// Purpose: Port checks for the transponder demodulator
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Bound to every tdm_demod instance
module tdm_demod_sva (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Configuration and carrier
  input wire logic immo_enable,
  input wire logic select_frequency,
  input wire logic frequency_rx_input,
  // Outputs
  input wire logic amplitude_ground,
  input wire logic amplitude_active,
  input wire logic frequency_active,
  input wire logic start_found,
  input wire logic demod_data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] edge_cnt;
  // Carrier edges seen since reset, saturating
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      edge_cnt <= 4'h0;
    end else if ($rose(frequency_rx_input) && edge_cnt != 4'hF) begin
      edge_cnt <= edge_cnt + 4'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_pulse;
    start_found ##1 !start_found;
  endsequence
  sequence s_quiet;
    !demod_data_out [*8];
  endsequence
  a_chan_excl: assert property (!(amplitude_active && frequency_active))
    else $error("both channels active");
  a_freq_wins: assert property (select_frequency |-> !amplitude_active)
    else $error("amplitude active with frequency selected");
  a_freq_on: assert property (immo_enable && select_frequency |-> frequency_active)
    else $error("frequency channel not active");
  a_amp_on: assert property (immo_enable && !select_frequency |-> amplitude_active)
    else $error("amplitude channel not active");
  a_ground_follow: assert property (amplitude_ground == !immo_enable)
    else $error("ground switch wrong");
  a_start_pulse: assert property (start_found |-> s_pulse)
    else $error("start pulse too long");
  a_start_chan: assert property (start_found |-> frequency_active)
    else $error("start outside frequency channel");
  a_start_edges: assert property (start_found |-> edge_cnt >= 4'hE)
    else $error("start seen before enough periods");
  a_idle_quiet: assert property (!amplitude_active && !frequency_active |=> !demod_data_out)
    else $error("data out with no channel active");
  a_byte_wait: assert property (start_found |=> s_quiet)
    else $error("data out before a byte was collected");
endmodule
bind tdm_demod tdm_demod_sva u_tdm_demod_sva (.clock(clock), .sys_rst(sys_rst),
  .immo_enable(immo_enable), .select_frequency(select_frequency),
  .frequency_rx_input(frequency_rx_input), .amplitude_ground(amplitude_ground),
  .amplitude_active(amplitude_active), .frequency_active(frequency_active),
  .start_found(start_found), .demod_data_out(demod_data_out));

/* test/tdm_transponder.sv */
// Purpose: Frequency keyed transponder reply, sliced carrier
// Assumes: 186 clocks per short period, 203 per long
// Notes:   Eight periods per data bit, carrier still outside replies
module tdm_transponder (
  input  wire logic        clock,
  input  wire logic        go,
  input  wire logic [15:0] bits,
  output logic             rx
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic per(input int n);
    rx = 1'b1;
    repeat (n / 2) @(negedge clock);
    rx = 1'b0;
    repeat (n - n / 2) @(negedge clock);
  endtask
  initial rx = 1'b0;
  always @(posedge go) begin
    // Resonance decay, then start pattern, then data MSB first; a long period is a one
    repeat (12) per(186);
    repeat (4) per(203);
    for (int i = 15; i >= 0; i--) begin
      repeat (8) per(bits[i] ? 203 : 186);
    end
    repeat (8) per(186);
  end
endmodule

/* test/tb_top.sv */
// Purpose: Self-checking bench for the transponder demodulator
// Assumes: Shortened phase filter counts of 40, 20 and 10 cycles
// Notes:   Inputs change at the falling edge
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import tdm_pkg::*;
  logic clock = 0, sys_rst = 1, immo_enable = 0, select_frequency = 0;
  logic dig_mod = 0, amplitude_rx_input = 0, go = 0;
  logic [1:0] data_rate = 0, glitch_setting = 0;
  logic [7:0] demod_start_delay = 8'h0A, early_start_time = 8'h04, bit_periods = 8'h08;
  logic frequency_rx_input, amplitude_ground, amplitude_active, frequency_active;
  logic start_found, demod_data_out;
  int n_errors = 0, cmp_count = 0, cyc = 0, n;
  always #20 clock = ~clock;
  tdm_demod #(.PHASE_2K(40), .PHASE_4K(20), .PHASE_8K(10)) u_tdm_demod (.clock(clock),
    .sys_rst(sys_rst), .immo_enable(immo_enable), .select_frequency(select_frequency),
    .data_rate(data_rate), .glitch_setting(glitch_setting),
    .demod_start_delay(demod_start_delay), .early_start_time(early_start_time),
    .dig_mod(dig_mod), .bit_periods(bit_periods), .amplitude_rx_input(amplitude_rx_input),
    .frequency_rx_input(frequency_rx_input), .amplitude_ground(amplitude_ground),
    .amplitude_active(amplitude_active), .frequency_active(frequency_active),
    .start_found(start_found), .demod_data_out(demod_data_out));
  tdm_transponder u_tdm_transponder (.clock(clock), .go(go), .bits(16'hB2C9),
    .rx(frequency_rx_input));
  task results;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task check(input string what, input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_errors++;
      $display("ERROR %s expected %0h seen %0h", what, want, seen);
    end
  endtask
  task rst;
    sys_rst = 1;
    repeat (16) @(negedge clock);
    sys_rst = 0;
  endtask
  // Latency from modulation high to data out for one rate and glitch setting
  task amp_case(input int r, input int g);
    int want;
    want = 150 + (r == 0 ? 40 : r == 1 ? 20 : 10);
    want += (g == 0 ? 0 : g == 1 ? GLITCH_CYC_1 : g == 2 ? GLITCH_CYC_2 : GLITCH_CYC_3)
            / (r == 0 ? 1 : r == 1 ? 2 : 4);
    rst;
    data_rate = r[1:0];
    glitch_setting = g[1:0];
    repeat (4) @(negedge clock);
    amplitude_rx_input = 1;
    dig_mod = 1;
    n = 0;
    while (demod_data_out !== 1'b1 && n < 6000) begin
      @(negedge clock);
      n++;
    end
    check("ask_latency", 32'(n >= want - 1 && n <= want + 4), 1);
    dig_mod = 0;
    amplitude_rx_input = 0;
  endtask
  task get_byte(input logic [7:0] want);
    logic [7:0] got;
    n = 0;
    while (demod_data_out !== 1'b1 && n < 20000) begin
      @(negedge clock);
      n++;
    end
    repeat (4) @(negedge clock);
    for (int i = 7; i >= 0; i--) begin
      got[i] = demod_data_out;
      repeat (8) @(negedge clock);
    end
    check("fsk_byte", got, want);
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      results;
    end
  end
  initial begin
    rst;
    check("ground_off", amplitude_ground, 1);
    immo_enable = 1;
    @(negedge clock);
    check("ground_on", amplitude_ground, 0);
    for (int s = 0; s < 2; s++) begin
      select_frequency = s[0];
      @(negedge clock);
      check("amp_active", amplitude_active, !s[0]);
      check("freq_active", frequency_active, s[0]);
    end
    select_frequency = 0;
    for (int r = 0; r < 4; r++) begin
      for (int g = 0; g < 4; g++) amp_case(r, g);
    end
    rst;
    select_frequency = 1;
    repeat (4) @(negedge clock);
    go = 1;
    n = 0;
    while (start_found !== 1'b1 && n < 10000) begin
      @(negedge clock);
      n++;
    end
    check("start_found", start_found, 1);
    check("start_time", 32'(n >= 3044 && n <= 3050), 1);
    get_byte(8'hB2);
    get_byte(8'hC9);
    results;
  end
endmodule
